/* spm_pkg.sv */
/*
 * Shared constants and types of the SWR and power alarm monitor.
 * Assumes a 20 MHz system clock and a 32-bit AHB-Lite register bus.
 */
package spm_pkg;

    // Clock and timebase.
    localparam int CLK_HZ    = 20_000_000;
    localparam int TICK_MS   = 1;
    localparam int TICK_CYC  = CLK_HZ / 1000 * TICK_MS;
    localparam int MS_PER_S  = 1000;

    // Register byte offsets.
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_FLOOR  = 8'h04;
    localparam logic [7:0] OFS_TDLY   = 8'h08;
    localparam logic [7:0] OFS_RINT   = 8'h0C;
    localparam logic [7:0] OFS_QUIET  = 8'h10;
    localparam logic [7:0] OFS_SWRT   = 8'h14;
    localparam logic [7:0] OFS_SWRW   = 8'h18;
    localparam logic [7:0] OFS_LOPWR  = 8'h1C;
    localparam logic [7:0] OFS_HIPWR  = 8'h20;
    localparam logic [7:0] OFS_COMMIT = 8'h24;
    localparam logic [7:0] OFS_STATUS = 8'h28;

    // Control register field positions.
    localparam int CTRL_EN_BIT   = 0;
    localparam int CTRL_DEV_LSB  = 1;
    localparam int CTRL_MODE_LSB = 3;

    // Legal ranges; SWR in tenths, floor in 0.1 W, powers in W, times in
    // ms, quiet interval in s. Zero means ignore for the SWR and power thresholds.
    localparam logic [6:0]  SWR_MIN   = 7'h0B;
    localparam logic [6:0]  SWR_MAX   = 7'h63;
    localparam logic [6:0]  FLOOR_MIN = 7'h01;
    localparam logic [6:0]  FLOOR_MAX = 7'h64;
    localparam logic [14:0] TIME_MIN  = 15'h0032;
    localparam logic [14:0] TIME_MAX  = 15'h7530;
    localparam logic [6:0]  QUIET_MIN = 7'h05;
    localparam logic [6:0]  QUIET_MAX = 7'h63;
    localparam logic [14:0] LO_MAX    = 15'h6B6C;
    localparam logic [14:0] HI_MAX    = 15'h7530;
    localparam logic [18:0] PWR_SCALE = 19'h0000A;

    typedef enum logic [1:0] {DEV_RELAY, DEV_SOUNDER, DEV_BOTH} spm_dev_t;
    typedef enum logic [1:0] {
        manual_reset_mode, auto_reset_mode, conditional_reset_mode
    } spm_mode_t;

    typedef struct packed {
        logic      en;
        spm_dev_t  dev;
        spm_mode_t mode;
    } spm_ctl_t;

    typedef struct packed {
        logic [6:0]  swr_power_floor;
        logic [14:0] trip_dly;
        logic [14:0] rst_int;
        logic [6:0]  quiet_interval_length;
        logic [6:0]  swr_trip;
        logic [6:0]  swr_warn;
        logic [14:0] lo_pwr;
        logic [14:0] hi_pwr;
    } spm_thr_t;

    // Reset values.
    localparam spm_ctl_t CTL_RST = '{en: 1'b0, dev: DEV_RELAY,
                                     mode: manual_reset_mode};
    localparam spm_thr_t THR_RST = '{swr_power_floor: 7'h0A,
        trip_dly: 15'h07D0, rst_int: 15'h0BB8,
        quiet_interval_length: 7'h14, swr_trip: 7'h28, swr_warn: 7'h1E,
        lo_pwr: 15'h0000, hi_pwr: 15'h0000};

    // Measurement in: SWR in tenths, power in 0.1 W.
    typedef struct packed {
        logic        valid;
        logic [6:0]  swr;
        logic [18:0] pwr;
    } spm_meas_t;

    typedef struct packed {
        logic clear_medium;
        logic snooze_long;
    } spm_btn_t;

    typedef struct packed {
        logic green;
        logic snooze;
        logic trip;
        logic warn;
        logic relay;
        logic sounder;
    } spm_ind_t;

endpackage

/* spm_monitor.sv */
/*
 * SWR and power alarm monitor with an AHB-Lite register slave.
 * Assumes measurements and button events synchronous to clock, one
 * cycle per button event, and single word transfers on the bus.
 */
`timescale 1ns/1ns
module spm_monitor #(
    parameter int TICK_CYCLES = spm_pkg::TICK_CYC
) (
    // Clock and reset.
    input  wire logic               clock,
    input  wire logic               srst,
    // AHB-Lite slave.
    input  wire logic               hsel,
    input  wire logic [31:0]        haddr,
    input  wire logic [1:0]         htrans,
    input  wire logic               hwrite,
    input  wire logic [2:0]         hsize,
    input  wire logic [31:0]        hwdata,
    input  wire logic               hready,
    output logic                    hreadyout,
    output logic                    hresp,
    output logic [31:0]             hrdata,
    // Measurements and front panel.
    input  wire spm_pkg::spm_meas_t meas,
    input  wire spm_pkg::spm_btn_t  btn,
    // Indicators and alarm drives.
    output spm_pkg::spm_ind_t       ind
);

    spm_pkg::spm_ctl_t ctl_r;
    spm_pkg::spm_thr_t thr_r;
    spm_pkg::spm_thr_t stage_r;
    logic              rej_r;
    logic              dph_wr_r;
    logic [7:0]        dph_addr_r;
    logic [31:0]       hrdata_r;
    logic [31:0]       rd_val;
    logic              sel_w;
    logic [14:0]       tick_cnt_r;
    logic              tick_r;
    logic [6:0]        swr_r;
    logic [18:0]       pwr_r;
    logic [14:0]       pwr_cnt_r;
    logic [14:0]       rst_cnt_r;
    logic [6:0]        quiet_s_r;
    logic [9:0]        quiet_ms_r;
    logic              trip_r;
    logic              warn_r;
    logic              swr_ok;
    logic              swr_fault;
    logic              lo_viol;
    logic              hi_viol;
    logic              pwr_fault;
    logic              fault_now;
    logic              snooze_on;
    logic              trip_set;
    logic              auto_clr;
    logic              conditional_reset_mode_clr;
    logic              commit_w;
    logic              stage_ok;

    // Checks a staged threshold set for ranges and consistency.
    function automatic logic thr_valid(spm_pkg::spm_thr_t t);
        logic ok;
        ok = 1'b1;
        if (t.swr_trip != 7'h00 && (t.swr_trip < spm_pkg::SWR_MIN ||
                t.swr_trip > spm_pkg::SWR_MAX)) begin
            ok = 1'b0;
        end
        if (t.swr_warn != 7'h00 && (t.swr_warn < spm_pkg::SWR_MIN ||
                t.swr_warn > spm_pkg::SWR_MAX)) begin
            ok = 1'b0;
        end
        if (t.swr_power_floor < spm_pkg::FLOOR_MIN ||
                t.swr_power_floor > spm_pkg::FLOOR_MAX) begin
            ok = 1'b0;
        end
        if (t.trip_dly < spm_pkg::TIME_MIN ||
                t.trip_dly > spm_pkg::TIME_MAX) begin
            ok = 1'b0;
        end
        if (t.rst_int < spm_pkg::TIME_MIN || t.rst_int > spm_pkg::TIME_MAX) begin
            ok = 1'b0;
        end
        if (t.quiet_interval_length < spm_pkg::QUIET_MIN ||
                t.quiet_interval_length > spm_pkg::QUIET_MAX) begin
            ok = 1'b0;
        end
        if (t.lo_pwr > spm_pkg::LO_MAX) begin
            ok = 1'b0;
        end
        if (t.hi_pwr > spm_pkg::HI_MAX) begin
            ok = 1'b0;
        end
        if (t.swr_trip == 7'h00 && t.lo_pwr == 15'h0000 &&
                t.hi_pwr == 15'h0000) begin
            ok = 1'b0;
        end
        if (t.lo_pwr != 15'h0000 && t.hi_pwr != 15'h0000 &&
                t.hi_pwr <= t.lo_pwr) begin
            ok = 1'b0;
        end
        return ok;
    endfunction
    // Bus slave: zero wait states, always OKAY.
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_r;
    assign sel_w     = hsel && hready && htrans[1];
    assign commit_w  = dph_wr_r && dph_addr_r == spm_pkg::OFS_COMMIT;
    assign stage_ok  = thr_valid(stage_r);

    always_ff @(posedge clock) begin
        if (srst) begin
            dph_wr_r   <= 1'b0;
            dph_addr_r <= 8'h00;
        end else if (hready) begin
            dph_wr_r   <= sel_w && hwrite;
            dph_addr_r <= haddr[7:0];
        end
    end

    always_comb begin
        rd_val = 32'h0000_0000;
        case (haddr[7:0])
            spm_pkg::OFS_CTRL:   rd_val[4:0] = {ctl_r.mode, ctl_r.dev, ctl_r.en};
            spm_pkg::OFS_FLOOR:  rd_val[6:0] = thr_r.swr_power_floor;
            spm_pkg::OFS_TDLY:   rd_val[14:0] = thr_r.trip_dly;
            spm_pkg::OFS_RINT:   rd_val[14:0] = thr_r.rst_int;
            spm_pkg::OFS_QUIET:  rd_val[6:0] = thr_r.quiet_interval_length;
            spm_pkg::OFS_SWRT:   rd_val[6:0] = thr_r.swr_trip;
            spm_pkg::OFS_SWRW:   rd_val[6:0] = thr_r.swr_warn;
            spm_pkg::OFS_LOPWR:  rd_val[14:0] = thr_r.lo_pwr;
            spm_pkg::OFS_HIPWR:  rd_val[14:0] = thr_r.hi_pwr;
            spm_pkg::OFS_STATUS: rd_val[4:0] = {ctl_r.en, rej_r, snooze_on,
                                                warn_r, trip_r};
            default:             rd_val = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            hrdata_r <= 32'h0000_0000;
        end else if (sel_w && !hwrite) begin
            hrdata_r <= rd_val;
        end
    end

    // Control writes act at once; codes that name no device or mode are
    // dropped and flagged.
    always_ff @(posedge clock) begin
        if (srst) begin
            ctl_r <= spm_pkg::CTL_RST;
        end else if (dph_wr_r && dph_addr_r == spm_pkg::OFS_CTRL &&
                hwdata[spm_pkg::CTRL_DEV_LSB+:2] != 2'h3 &&
                hwdata[spm_pkg::CTRL_MODE_LSB+:2] != 2'h3) begin
            ctl_r.en   <= hwdata[spm_pkg::CTRL_EN_BIT];
            ctl_r.dev  <= spm_pkg::spm_dev_t'(hwdata[spm_pkg::CTRL_DEV_LSB+:2]);
            ctl_r.mode <= spm_pkg::spm_mode_t'(hwdata[spm_pkg::CTRL_MODE_LSB+:2]);
        end
    end

    // Threshold writes land in the staging set until committed.
    always_ff @(posedge clock) begin
        if (srst) begin
            stage_r <= spm_pkg::THR_RST;
        end else if (dph_wr_r) begin
            case (dph_addr_r)
                spm_pkg::OFS_FLOOR: stage_r.swr_power_floor <= hwdata[6:0];
                spm_pkg::OFS_TDLY:  stage_r.trip_dly <= hwdata[14:0];
                spm_pkg::OFS_RINT:  stage_r.rst_int <= hwdata[14:0];
                spm_pkg::OFS_QUIET: stage_r.quiet_interval_length <= hwdata[6:0];
                spm_pkg::OFS_SWRT:  stage_r.swr_trip <= hwdata[6:0];
                spm_pkg::OFS_SWRW:  stage_r.swr_warn <= hwdata[6:0];
                spm_pkg::OFS_LOPWR: stage_r.lo_pwr <= hwdata[14:0];
                spm_pkg::OFS_HIPWR: stage_r.hi_pwr <= hwdata[14:0];
                default:            stage_r <= stage_r;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            thr_r <= spm_pkg::THR_RST;
            rej_r <= 1'b0;
        end else if (commit_w) begin
            if (stage_ok) begin
                thr_r <= stage_r;
            end
            rej_r <= !stage_ok;
        end else if (dph_wr_r && dph_addr_r == spm_pkg::OFS_CTRL) begin
            rej_r <= hwdata[spm_pkg::CTRL_DEV_LSB+:2] == 2'h3 ||
                     hwdata[spm_pkg::CTRL_MODE_LSB+:2] == 2'h3;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            tick_cnt_r <= 15'h0000;
            tick_r     <= 1'b0;
        end else if (tick_cnt_r == 15'(TICK_CYCLES - 1)) begin
            tick_cnt_r <= 15'h0000;
            tick_r     <= 1'b1;
        end else begin
            tick_cnt_r <= tick_cnt_r + 15'h0001;
            tick_r     <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            swr_r <= 7'h00;
            pwr_r <= 19'h00000;
        end else if (meas.valid) begin
            swr_r <= meas.swr;
            pwr_r <= meas.pwr;
        end
    end

    assign swr_ok = pwr_r >= {12'h000, thr_r.swr_power_floor};
    assign swr_fault = thr_r.swr_trip != 7'h00 && swr_ok &&
                       swr_r > thr_r.swr_trip;
    assign lo_viol = thr_r.lo_pwr != 15'h0000 &&
                     pwr_r < {4'h0, thr_r.lo_pwr} * spm_pkg::PWR_SCALE;
    assign hi_viol = thr_r.hi_pwr != 15'h0000 &&
                     pwr_r > {4'h0, thr_r.hi_pwr} * spm_pkg::PWR_SCALE;
    assign pwr_fault = (lo_viol || hi_viol) && pwr_cnt_r >= thr_r.trip_dly;
    assign fault_now = swr_fault || lo_viol || hi_viol;
    assign snooze_on = quiet_s_r != 7'h00;
    assign trip_set = ctl_r.en && !snooze_on && (swr_fault || pwr_fault);
    assign auto_clr = trip_r && ctl_r.mode == spm_pkg::auto_reset_mode &&
                      rst_cnt_r >= thr_r.rst_int;
    assign conditional_reset_mode_clr = trip_r && ctl_r.mode == spm_pkg::conditional_reset_mode &&
                      rst_cnt_r >= thr_r.rst_int && !fault_now;

    always_ff @(posedge clock) begin
        if (srst || !(lo_viol || hi_viol) || auto_clr) begin
            pwr_cnt_r <= 15'h0000;
        end else if (tick_r && pwr_cnt_r != spm_pkg::TIME_MAX) begin
            pwr_cnt_r <= pwr_cnt_r + 15'h0001;
        end
    end

    always_ff @(posedge clock) begin
        if (srst || !trip_r || ctl_r.mode == spm_pkg::manual_reset_mode) begin
            rst_cnt_r <= 15'h0000;
        end else if (tick_r && rst_cnt_r != spm_pkg::TIME_MAX) begin
            rst_cnt_r <= rst_cnt_r + 15'h0001;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            quiet_s_r  <= 7'h00;
            quiet_ms_r <= 10'h000;
        end else if (btn.snooze_long) begin
            quiet_s_r  <= thr_r.quiet_interval_length;
            quiet_ms_r <= 10'h000;
        end else if (snooze_on && tick_r) begin
            if (quiet_ms_r == 10'(spm_pkg::MS_PER_S - 1)) begin
                quiet_ms_r <= 10'h000;
                quiet_s_r  <= quiet_s_r - 7'h01;
            end else begin
                quiet_ms_r <= quiet_ms_r + 10'h001;
            end
        end
    end
    // Timed clears win over a new set so that a lasting fault shows as a
    // retrip; a clear press loses to a set in the same cycle.
    always_ff @(posedge clock) begin
        if (srst) begin
            trip_r <= 1'b0;
        end else if (btn.snooze_long) begin
            trip_r <= 1'b0;
        end else if (auto_clr || conditional_reset_mode_clr) begin
            trip_r <= 1'b0;
        end else if (trip_set) begin
            trip_r <= 1'b1;
        end else if (btn.clear_medium) begin
            trip_r <= 1'b0;
        end
    end
    always_ff @(posedge clock) begin
        if (srst) begin
            warn_r <= 1'b0;
        end else begin
            warn_r <= thr_r.swr_warn != 7'h00 && swr_ok &&
                      swr_r > thr_r.swr_warn;
        end
    end
    always_comb begin
        ind.green   = ctl_r.en;
        ind.snooze  = snooze_on;
        ind.trip    = trip_r;
        ind.warn    = warn_r;
        ind.relay   = trip_r && ctl_r.dev != spm_pkg::DEV_SOUNDER;
        ind.sounder = trip_r && ctl_r.dev != spm_pkg::DEV_RELAY;
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (srst);

    chk_trip_latch_swr: assert property (
        ctl_r.en && !snooze_on && swr_fault && !btn.snooze_long &&
        !auto_clr && !conditional_reset_mode_clr |=> trip_r && ind.trip)
        else $error("SWR fault did not latch a trip");
    chk_relay_select: assert property (
        ind.relay == (trip_r && ctl_r.dev != spm_pkg::DEV_SOUNDER) &&
        ind.sounder == (trip_r && ctl_r.dev != spm_pkg::DEV_RELAY))
        else $error("Alarm drive does not match device select");
    chk_warn_follow: assert property (
        swr_ok && thr_r.swr_warn != 7'h00 && swr_r <= thr_r.swr_warn
        ##1 $stable(swr_r) && $stable(thr_r) |-> !ind.warn)
        else $error("Warning stayed on below threshold");
    chk_quiet_blocks: assert property (
        snooze_on && !trip_r |=> !trip_r)
        else $error("Trip latched during quiet interval");
    chk_snooze_clears: assert property (
        btn.snooze_long |=> !trip_r && ind.snooze)
        else $error("Snooze start did not clear trip");
    chk_manual_hold: assert property (
        ctl_r.mode == spm_pkg::manual_reset_mode && trip_r &&
        !btn.clear_medium && !btn.snooze_long |=> trip_r)
        else $error("Manual trip cleared without a press");
    chk_conditional_reset_mode_hold: assert property (
        ctl_r.mode == spm_pkg::conditional_reset_mode && trip_r && fault_now &&
        !btn.clear_medium && !btn.snooze_long |=> trip_r)
        else $error("Conditional trip cleared with fault present");
    chk_clear_press: assert property (
        trip_r && btn.clear_medium && !trip_set |=> !trip_r)
        else $error("Clear press did not reset trip");
    chk_pwr_delay: assert property (
        !(lo_viol || hi_viol) |=> pwr_cnt_r == 15'h0000)
        else $error("Violation timer not restarted by a gap");
    chk_floor_gate: assert property (
        !swr_ok |=> !warn_r)
        else $error("Warning raised below power floor");
    chk_reject_keep: assert property (
        commit_w && !stage_ok |=> $stable(thr_r) && rej_r)
        else $error("Invalid configuration was accepted");
    chk_tick_spacing: assert property (
        tick_r |=> !tick_r [*2])
        else $error("Millisecond tick fired too often");

endmodule

/* spm_panel_model.sv */
/*
 * Measurement source and front-panel button model for the alarm monitor.
 * Assumes the bench calls its tasks; all drives change after a rising edge.
 */
`timescale 1ns/1ns
module spm_panel_model (
    // Clock.
    input  wire logic           clock,
    // Drives into the monitor.
    output spm_pkg::spm_meas_t  meas,
    output spm_pkg::spm_btn_t   btn
);
    initial begin
        meas = '0;
        btn  = '0;
    end

    // Between strobes the value lines show the inverse of the last sample.
    task automatic send(input logic [6:0] swr, input logic [18:0] pwr);
        @(posedge clock);
        meas <= '{valid: 1'b1, swr: swr, pwr: pwr};
        @(posedge clock);
        meas <= '{valid: 1'b0, swr: ~swr, pwr: ~pwr};
    endtask

    task automatic press(input logic clr);
        @(posedge clock);
        btn <= '{clear_medium: clr, snooze_long: ~clr};
        @(posedge clock);
        btn <= '0;
    endtask
endmodule

/* tb_spm_monitor.sv */
/*
 * Self-checking bench for the alarm monitor: AHB-Lite register tasks and
 * measurement sequences. Assumes one slave, so hready is hreadyout.
 */
`timescale 1ns/1ns
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_errors++; \
    $display("wrong value %s expected %h seen %h", nm, e, g); end end
module tb_spm_monitor;
    logic               clock  = 1'b0;
    logic               srst   = 1'b1;
    logic               hsel   = 1'b0;
    logic               hwrite = 1'b0;
    logic [1:0]         htrans = 2'h0;
    logic [2:0]         hsize  = 3'h2;
    logic [31:0]        haddr  = 32'h0;
    logic [31:0]        hwdata = 32'h0;
    logic [31:0]        hrdata;
    logic [31:0]        rd;
    logic               hreadyout;
    logic               hresp;
    spm_pkg::spm_meas_t meas;
    spm_pkg::spm_btn_t  btn;
    spm_pkg::spm_ind_t  ind;
    int                 n_errors = 0;
    int                 compares = 0;
    int                 cyc      = 0;
    int                 w;
    localparam logic [31:0] RV [12] = '{32'h0, 32'h0A, 32'h7D0, 32'hBB8,
        32'h14, 32'h28, 32'h1E, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};

    spm_monitor #(.TICK_CYCLES(4)) u_spm_monitor (
        .clock(clock), .srst(srst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .meas(meas), .btn(btn), .ind(ind));
    spm_panel_model u_spm_panel_model (
        .clock(clock), .meas(meas), .btn(btn));

    always #25 clock = ~clock;

    task automatic close_out();
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    always @(posedge clock) begin
        cyc++;
        if (cyc == 40000) begin
            n_errors++;
            close_out();
        end
    end

    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clock);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge clock); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clock); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    // Waits until one indicator bit reaches v; w counts the cycles taken.
    task automatic wait_for(input int b, input logic v, input int lim);
        w = 0;
        while (ind[b] !== v && w < lim) begin
            step(1);
            w++;
        end
    endtask

    initial begin
        repeat (12) @(posedge clock);
        srst <= 1'b0;
        for (int i = 0; i < 12; i++) begin
            if (i != 9) begin
                bus(1'b0, 8'(i * 4), 32'h0);
                `CHK("reset value", RV[i], rd)
            end
        end
        bus(1'b1, spm_pkg::OFS_QUIET, 32'h5);
        bus(1'b1, spm_pkg::OFS_RINT, 32'h32);
        bus(1'b1, spm_pkg::OFS_TDLY, 32'h32);
        bus(1'b1, spm_pkg::OFS_COMMIT, 32'h0);
        bus(1'b0, spm_pkg::OFS_QUIET, 32'h0);
        `CHK("quiet", 32'h5, rd)
        bus(1'b1, spm_pkg::OFS_CTRL, 32'h1);
        step(1);
        `CHK("green", 1'b1, ind.green)
        u_spm_panel_model.send(7'h23, 19'h14);
        step(3);
        `CHK("warn on", 2'b01, {ind.trip, ind.warn})
        u_spm_panel_model.send(7'h14, 19'h14);
        step(3);
        `CHK("warn off", 1'b0, ind.warn)
        u_spm_panel_model.send(7'h23, 19'h5);
        step(3);
        `CHK("warn floor", 1'b0, ind.warn)
        for (int d = 0; d < 3; d++) begin
            bus(1'b1, spm_pkg::OFS_CTRL, 32'(1 + d * 2));
            u_spm_panel_model.send(7'h32, 19'h14);
            step(3);
            `CHK("trip", 1'b1, ind.trip)
            `CHK("relay", 1'(d != 1), ind.relay)
            `CHK("sounder", 1'(d != 0), ind.sounder)
            u_spm_panel_model.send(7'h14, 19'h14);
            step(20);
            `CHK("latched", 1'b1, ind.trip)
            u_spm_panel_model.press(1'b1);
            step(1);
            `CHK("cleared", 1'b0, ind.trip)
        end
        bus(1'b1, spm_pkg::OFS_HIPWR, 32'h64);
        bus(1'b1, spm_pkg::OFS_COMMIT, 32'h0);
        bus(1'b1, spm_pkg::OFS_CTRL, 32'h9);
        u_spm_panel_model.send(7'h0A, 19'h5DC);
        step(120);
        u_spm_panel_model.send(7'h0A, 19'h1F4);
        u_spm_panel_model.send(7'h0A, 19'h5DC);
        step(180);
        `CHK("gap restart", 1'b0, ind.trip)
        wait_for(3, 1'b1, 60);
        `CHK("power trip", 1'b1, ind.trip)
        wait_for(3, 1'b0, 260);
        `CHK("auto clear", 1'b0, ind.trip)
        step(150);
        `CHK("auto gap", 1'b0, ind.trip)
        wait_for(3, 1'b1, 100);
        `CHK("auto retrip", 1'b1, ind.trip)
        bus(1'b1, spm_pkg::OFS_CTRL, 32'h11);
        step(300);
        `CHK("conditional_reset_mode hold", 1'b1, ind.trip)
        u_spm_panel_model.send(7'h0A, 19'h1F4);
        wait_for(3, 1'b0, 10);
        `CHK("conditional_reset_mode clear", 1'b0, ind.trip)
        bus(1'b1, spm_pkg::OFS_CTRL, 32'h1);
        u_spm_panel_model.send(7'h32, 19'h1F4);
        step(3);
        `CHK("swr trip", 1'b1, ind.trip)
        u_spm_panel_model.press(1'b0);
        step(1);
        `CHK("snooze start", 2'b10, {ind.snooze, ind.trip})
        step(50);
        `CHK("fault ignored", 1'b0, ind.trip)
        wait_for(4, 1'b0, 20100);
        `CHK("snooze end", 1'b0, ind.snooze)
        `CHK("snooze length", 1'b1, 1'(w > 19900))
        bus(1'b1, spm_pkg::OFS_LOPWR, 32'hC8);
        bus(1'b1, spm_pkg::OFS_COMMIT, 32'h0);
        bus(1'b0, spm_pkg::OFS_STATUS, 32'h0);
        `CHK("reject", 1'b1, rd[3])
        bus(1'b0, spm_pkg::OFS_HIPWR, 32'h0);
        `CHK("kept high", 32'h64, rd)
        bus(1'b1, spm_pkg::OFS_CTRL, 32'h1);
        bus(1'b1, spm_pkg::OFS_LOPWR, 32'h0);
        bus(1'b1, spm_pkg::OFS_HIPWR, 32'h0);
        bus(1'b1, spm_pkg::OFS_SWRT, 32'h0);
        bus(1'b0, spm_pkg::OFS_STATUS, 32'h0);
        `CHK("reject off", 1'b0, rd[3])
        bus(1'b1, spm_pkg::OFS_COMMIT, 32'h0);
        bus(1'b0, spm_pkg::OFS_STATUS, 32'h0);
        `CHK("all ignored", 1'b1, rd[3])
        bus(1'b0, spm_pkg::OFS_SWRT, 32'h0);
        `CHK("kept swr", 32'h28, rd)
        close_out();
    end
endmodule
